// File: sw_enc_regs.svh
`ifndef SW_ENC_REGS_SVH
`define SW_ENC_REGS_SVH

// ==========================================================
// Status byte codes
`define SW1_NORMAL      8'h90
`define SW1_PROACTIVE   8'h91
`define SW1_BUSY        8'h93
`define SW1_REFERENCE   8'h94
`define SW1_BAD_LENGTH  8'h67
`define SW1_BAD_PARAM   8'h6b
`define SW1_BAD_INS     8'h6d
`define SW1_BAD_CLASS   8'h6e
`define SW1_TECH_FAULT  8'h6f
`define SW2_NONE        8'h00
`define SW2_OUT_RANGE   8'h02

// ==========================================================
// Stored content fill values
`define FILL_BYTE       8'hff
`define FILL_NIBBLE     4'hf
`define DELETED_LAST    8'hfe
`define ALPHA_MSB_POS   7

// ==========================================================
// File store geometry
`define FILE_DEPTH      16
`define FILE_AW         4

`endif

// File: sw_enc_pkg.sv
package sw_enc_pkg;

    // ======================================================
    // Command classes
    typedef enum logic [3:0] {
        CMD_SELECT, CMD_STATUS, CMD_FILE_RW, CMD_SEEK1, CMD_SEEK2,
        CMD_CHV, CMD_INVAL, CMD_ALGO, CMD_SLEEP, CMD_GET_RESP,
        CMD_TOOLKIT, CMD_FETCH, CMD_UNKNOWN
    } cmd_kind_t;

    typedef struct packed {
        logic [7:0] cls;
        logic [7:0] ins;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] p3;
    } cmd_hdr_t;

    typedef struct packed {
        logic       class_ok;
        logic       length_ok;
        logic [7:0] right_length;
        logic       param_ok;
        logic       record_out_of_range;
        logic       tech_fault;
        logic       proactive_pending;
        logic [7:0] proactive_length;
        logic       toolkit_busy;
    } cmd_check_t;

    typedef struct packed {
        logic [7:0] sw1;
        logic [7:0] sw2;
    } status_word_t;

    typedef enum logic [1:0] {
        FILL_UNASSIGNED, FILL_DELETED_LAI, FILL_OPTIONAL, FILL_ALPHA
    } fill_kind_t;

endpackage

// File: file_store.sv
`timescale 1ns/1ns
`include "sw_enc_regs.svh"

module file_store (
    input  wire logic                 core_clk,
    input  wire logic                 we,
    input  wire logic [`FILE_AW-1:0]  waddr,
    input  wire logic [7:0]           wdata,
    input  wire logic [`FILE_AW-1:0]  raddr,
    output logic [7:0]                rdata
);
    logic [7:0] mem [`FILE_DEPTH];

    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// File: card_status_word_encoder.sv
`timescale 1ns/1ns
`include "sw_enc_regs.svh"

// Function
// - Bad length gives first byte 67
// - Length error second byte: correct length
// - Bad P1/P2 gives first byte 6B
// - Unknown instruction gives first byte 6D
// - Wrong class gives first byte 6E
// - Undiagnosed technical fault gives 6F
// - Error codes 6B, 6D, 6E and 6F carry second byte 00
// - Record out of range gives 94 02
// - 91/93 only when both support toolkit
// - Seek type two defers 91 to retrieval
// - Status restricted to command's permitted set
// - Unassigned or cleared bytes read FF
// - Deleted location code ends with FE
// - Optional items filled with F nibbles
// - Alphabet characters have bit 8 cleared
// - Success answers 90 00
// - 94 02 means invalid address reference
module card_status_word_encoder (
    input  wire logic                    core_clk,
    input  wire logic                    arst_n,
    input  wire logic                    cmd_valid,
    input  wire sw_enc_pkg::cmd_hdr_t    cmd_hdr,
    input  wire sw_enc_pkg::cmd_check_t  cmd_check,
    input  wire logic                    card_toolkit,
    input  wire logic                    handset_toolkit,
    input  wire logic                    fill_valid,
    input  wire sw_enc_pkg::fill_kind_t  fill_kind,
    input  wire logic [`FILE_AW-1:0]     fill_addr,
    input  wire logic [7:0]              fill_data,
    input  wire logic                    fill_last,
    input  wire logic [`FILE_AW-1:0]     file_raddr,
    output logic [7:0]                   file_rdata,
    output logic                         sw_valid,
    output sw_enc_pkg::status_word_t     status_word,
    output logic                         seek_pending
);
    // ======================================================
    // Command decode
    function automatic sw_enc_pkg::cmd_kind_t decode_ins(input logic [7:0] ins);
        unique case (ins)
            8'ha4:          decode_ins = sw_enc_pkg::CMD_SELECT;
            8'hf2:          decode_ins = sw_enc_pkg::CMD_STATUS;
            8'hd6, 8'hdc,
            8'hb0, 8'hb2,
            8'h32:          decode_ins = sw_enc_pkg::CMD_FILE_RW;
            8'ha2:          decode_ins = sw_enc_pkg::CMD_SEEK1;
            8'h20, 8'h24,
            8'h26, 8'h28,
            8'h2c:          decode_ins = sw_enc_pkg::CMD_CHV;
            8'h04, 8'h44:   decode_ins = sw_enc_pkg::CMD_INVAL;
            8'h88:          decode_ins = sw_enc_pkg::CMD_ALGO;
            8'hfa:          decode_ins = sw_enc_pkg::CMD_SLEEP;
            8'hc0:          decode_ins = sw_enc_pkg::CMD_GET_RESP;
            8'h10, 8'hc2,
            8'h14:          decode_ins = sw_enc_pkg::CMD_TOOLKIT;
            8'h12:          decode_ins = sw_enc_pkg::CMD_FETCH;
            default:        decode_ins = sw_enc_pkg::CMD_UNKNOWN;
        endcase
    endfunction

    // Seek mode lives in P2 high nibble; type two is when P2 bit 4 is set
    sw_enc_pkg::cmd_kind_t kind_raw;
    sw_enc_pkg::cmd_kind_t kind;
    assign kind_raw = decode_ins(cmd_hdr.ins);
    assign kind     = (kind_raw == sw_enc_pkg::CMD_SEEK1 && cmd_hdr.p2[4])
                      ? sw_enc_pkg::CMD_SEEK2 : kind_raw;

    // ======================================================
    // Permitted sets
    wire toolkit_ok  = card_toolkit && handset_toolkit;
    wire class_ok    = cmd_check.class_ok && cmd_hdr.cls == 8'ha0;
    wire ins_known   = kind != sw_enc_pkg::CMD_UNKNOWN;
    wire may_91      = toolkit_ok && kind != sw_enc_pkg::CMD_SEEK2
                       && kind != sw_enc_pkg::CMD_ALGO && kind != sw_enc_pkg::CMD_SLEEP
                       && kind != sw_enc_pkg::CMD_STATUS;
    wire may_busy    = toolkit_ok && kind == sw_enc_pkg::CMD_TOOLKIT;
    wire may_94      = kind inside {sw_enc_pkg::CMD_SELECT, sw_enc_pkg::CMD_FILE_RW,
                                    sw_enc_pkg::CMD_SEEK1, sw_enc_pkg::CMD_SEEK2,
                                    sw_enc_pkg::CMD_INVAL};
    wire get_91      = kind == sw_enc_pkg::CMD_GET_RESP && seek_pending && toolkit_ok;

    // ======================================================
    // Priority encode
    sw_enc_pkg::status_word_t sw_d;
    always_comb begin
        sw_d = '{sw1: `SW1_NORMAL, sw2: `SW2_NONE};
        if (!class_ok) begin
            sw_d = '{sw1: `SW1_BAD_CLASS, sw2: `SW2_NONE};
        end else if (!ins_known) begin
            sw_d = '{sw1: `SW1_BAD_INS, sw2: `SW2_NONE};
        end else if (cmd_check.tech_fault) begin
            sw_d = '{sw1: `SW1_TECH_FAULT, sw2: `SW2_NONE};
        end else if (!cmd_check.param_ok && cmd_check.record_out_of_range && may_94) begin
            sw_d = '{sw1: `SW1_REFERENCE, sw2: `SW2_OUT_RANGE};
        end else if (!cmd_check.param_ok) begin
            sw_d = '{sw1: `SW1_BAD_PARAM, sw2: `SW2_NONE};
        end else if (!cmd_check.length_ok) begin
            sw_d = '{sw1: `SW1_BAD_LENGTH, sw2: cmd_check.right_length};
        end else if (cmd_check.toolkit_busy && may_busy) begin
            sw_d = '{sw1: `SW1_BUSY, sw2: `SW2_NONE};
        end else if ((cmd_check.proactive_pending && may_91) || get_91) begin
            sw_d = '{sw1: `SW1_PROACTIVE, sw2: cmd_check.proactive_length};
        end
    end

    wire seek2_hit = cmd_valid && sw_d.sw1 == `SW1_NORMAL
                     && kind == sw_enc_pkg::CMD_SEEK2 && cmd_check.proactive_pending;
    wire seek_clr  = cmd_valid && kind == sw_enc_pkg::CMD_GET_RESP;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sw_valid     <= 1'b0;
            status_word  <= '{sw1: `SW1_NORMAL, sw2: `SW2_NONE};
            seek_pending <= 1'b0;
        end else begin
            sw_valid <= cmd_valid;
            if (cmd_valid) begin
                status_word <= sw_d;
            end
            if (seek2_hit) begin
                seek_pending <= 1'b1;
            end else if (seek_clr) begin
                seek_pending <= 1'b0;
            end
        end
    end

    // ======================================================
    // Content fill
    logic [7:0] fill_byte;
    always_comb begin
        unique case (fill_kind)
            sw_enc_pkg::FILL_UNASSIGNED:  fill_byte = `FILL_BYTE;
            sw_enc_pkg::FILL_DELETED_LAI:
                fill_byte = fill_last ? `DELETED_LAST : fill_data;
            sw_enc_pkg::FILL_OPTIONAL:    fill_byte = {`FILL_NIBBLE, `FILL_NIBBLE};
            sw_enc_pkg::FILL_ALPHA:
                fill_byte = {1'b0, fill_data[`ALPHA_MSB_POS-1:0]};
        endcase
    end

    // Read data registered inside the store, so the output stays a flop
    file_store u_store (
        .core_clk (core_clk),
        .we       (fill_valid),
        .waddr    (fill_addr),
        .wdata    (fill_byte),
        .raddr    (file_raddr),
        .rdata    (file_rdata)
    );

    // ======================================================
    // Checks
    a_class_first: assert property (@(posedge core_clk) disable iff (!arst_n)
        cmd_valid && !class_ok |=> status_word.sw1 == `SW1_BAD_CLASS)
        else $error("class error not reported first");
    a_ins_unknown: assert property (@(posedge core_clk) disable iff (!arst_n)
        cmd_valid && class_ok && !ins_known |=> status_word == 16'h6d00)
        else $error("unknown instruction not reported");
    a_len_echo: assert property (@(posedge core_clk) disable iff (!arst_n)
        cmd_valid && sw_d.sw1 == `SW1_BAD_LENGTH
        |=> status_word.sw2 == $past(cmd_check.right_length))
        else $error("length error lacks correct length");
    a_range_code: assert property (@(posedge core_clk) disable iff (!arst_n)
        cmd_valid && class_ok && ins_known && !cmd_check.tech_fault && may_94
        && !cmd_check.param_ok && cmd_check.record_out_of_range
        |=> status_word == 16'h9402)
        else $error("out of range record not 94 02");
    a_param_code: assert property (@(posedge core_clk) disable iff (!arst_n)
        sw_valid && status_word.sw1 == `SW1_BAD_PARAM |-> status_word.sw2 == 8'h00)
        else $error("parameter error second byte not 00");
    a_toolkit_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
        cmd_valid && !toolkit_ok |=> !(status_word.sw1 inside {8'h91, 8'h93}))
        else $error("toolkit status without support");
    a_seek_defer: assert property (@(posedge core_clk) disable iff (!arst_n)
        cmd_valid && kind == sw_enc_pkg::CMD_SEEK2 |=> status_word.sw1 != 8'h91)
        else $error("type two seek answered 91 directly");
    a_ok_default: assert property (@(posedge core_clk) disable iff (!arst_n)
        cmd_valid && class_ok && ins_known && cmd_check.param_ok && cmd_check.length_ok
        && !cmd_check.tech_fault && !cmd_check.proactive_pending && !get_91
        && !(cmd_check.toolkit_busy && may_busy)
        |=> status_word == 16'h9000)
        else $error("success not 90 00");
    a_alpha_msb: assert property (@(posedge core_clk) disable iff (!arst_n)
        fill_kind == sw_enc_pkg::FILL_ALPHA |-> !fill_byte[`ALPHA_MSB_POS])
        else $error("alphabet byte msb set");

    c_length_err: cover property (@(posedge core_clk) disable iff (!arst_n)
        sw_valid && status_word.sw1 == `SW1_BAD_LENGTH);
    c_seek_then_get: cover property (@(posedge core_clk) disable iff (!arst_n)
        seek2_hit ##[1:20] (sw_valid && status_word.sw1 == `SW1_PROACTIVE));
    c_range: cover property (@(posedge core_clk) disable iff (!arst_n)
        sw_valid && status_word == 16'h9402);
endmodule

// File: handset_model.sv
`timescale 1ns/1ns

// ==========================================================
// Handset terminal side: one command header per call
module handset_model (
    input  wire logic              core_clk,
    output logic                   cmd_valid,
    output sw_enc_pkg::cmd_hdr_t   cmd_hdr,
    output sw_enc_pkg::cmd_check_t cmd_check
);
    initial begin
        cmd_valid = 1'b0;
        cmd_hdr   = '0;
        cmd_check = '0;
    end

    task automatic issue(input sw_enc_pkg::cmd_hdr_t h, input sw_enc_pkg::cmd_check_t k);
        @(posedge core_clk);
        #2;
        cmd_valid = 1'b1;
        cmd_hdr   = h;
        cmd_check = k;
    endtask

    // Idle fields invert so a stale header never looks valid
    task automatic idle();
        @(posedge core_clk);
        #2;
        cmd_valid = 1'b0;
        cmd_hdr   = ~cmd_hdr;
        cmd_check = ~cmd_check;
    endtask
endmodule

// File: test_card_status_word_encoder.sv
`timescale 1ns/1ns
`include "sw_enc_regs.svh"

module test_card_status_word_encoder;
    localparam sw_enc_pkg::cmd_check_t OK = '{class_ok: 1'b1, length_ok: 1'b1,
                                              param_ok: 1'b1, default: '0};
    logic                     core_clk = 1'b0;
    logic                     arst_n = 1'b0;
    logic                     cmd_valid, sw_valid, seek_pending;
    logic                     exp_seek = 1'b0;
    sw_enc_pkg::cmd_hdr_t     cmd_hdr;
    sw_enc_pkg::cmd_check_t   cmd_check, c;
    logic                     card_toolkit = 1'b0;
    logic                     handset_toolkit = 1'b0;
    logic                     fill_valid = 1'b0;
    sw_enc_pkg::fill_kind_t   fill_kind = sw_enc_pkg::FILL_UNASSIGNED;
    logic [`FILE_AW-1:0]      fill_addr = '0;
    logic [`FILE_AW-1:0]      file_raddr = '0;
    logic [7:0]               fill_data = 8'h00;
    logic                     fill_last = 1'b0;
    logic [7:0]               file_rdata;
    logic [7:0]               fexp [8];
    sw_enc_pkg::status_word_t status_word;
    logic [15:0]              q [$];
    int                       seed = 19538;
    int                       bad_count = 0;
    int                       comparisons = 0;
    int                       cycles = 0;
    logic [7:0]               tbl [18] = '{8'ha4, 8'hf2, 8'hd6, 8'hdc, 8'hb0, 8'hb2, 8'h20,
        8'h24, 8'h26, 8'h28, 8'h2c, 8'h88, 8'hfa, 8'h10, 8'hc2, 8'h14, 8'h12, 8'h77};

    always #10 core_clk = ~core_clk;

    handset_model hs_u (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_hdr(cmd_hdr),
                        .cmd_check(cmd_check));

    card_status_word_encoder dut_u (.core_clk(core_clk), .arst_n(arst_n),
        .cmd_valid(cmd_valid), .cmd_hdr(cmd_hdr), .cmd_check(cmd_check),
        .card_toolkit(card_toolkit), .handset_toolkit(handset_toolkit),
        .fill_valid(fill_valid), .fill_kind(fill_kind), .fill_addr(fill_addr),
        .fill_data(fill_data), .fill_last(fill_last), .file_raddr(file_raddr),
        .file_rdata(file_rdata), .sw_valid(sw_valid), .status_word(status_word),
        .seek_pending(seek_pending));

    // ======================================================
    // Reference answer, first failing check wins
    function automatic logic [15:0] expect_sw(sw_enc_pkg::cmd_hdr_t h,
                                              sw_enc_pkg::cmd_check_t k, logic tk);
        logic known, rng, pro;
        known = h.ins inside {8'ha4, 8'hf2, 8'hd6, 8'hdc, 8'hb0, 8'hb2, 8'h32, 8'ha2,
            8'h20, 8'h24, 8'h26, 8'h28, 8'h2c, 8'h04, 8'h44, 8'h88, 8'hfa, 8'hc0,
            8'h10, 8'hc2, 8'h14, 8'h12};
        rng = h.ins inside {8'ha4, 8'hd6, 8'hdc, 8'hb0, 8'hb2, 8'h32, 8'ha2, 8'h04, 8'h44};
        pro = !(h.ins inside {8'hf2, 8'h88, 8'hfa}) && !(h.ins == 8'ha2 && h.p2[4]);
        if (!k.class_ok) return 16'h6e00;
        if (!known) return 16'h6d00;
        if (k.tech_fault) return 16'h6f00;
        if (!k.param_ok && k.record_out_of_range && rng) return 16'h9402;
        if (!k.param_ok) return 16'h6b00;
        if (!k.length_ok) return {8'h67, k.right_length};
        if (k.toolkit_busy && tk && h.ins inside {8'h10, 8'hc2, 8'h14}) return 16'h9300;
        if (tk && ((k.proactive_pending && pro) || (h.ins == 8'hc0 && exp_seek)))
            return {8'h91, k.proactive_length};
        return 16'h9000;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic send(input logic [7:0] ins, input logic [7:0] p2,
                        input sw_enc_pkg::cmd_check_t k, input logic [1:0] tk);
        sw_enc_pkg::cmd_hdr_t h;
        logic [15:0]          e;
        h = '{cls: k.class_ok ? 8'ha0 : 8'h3c, ins: ins, p1: 8'h00, p2: p2, p3: 8'h10};
        hs_u.issue(h, k);
        card_toolkit = tk[1];
        handset_toolkit = tk[0];
        e = expect_sw(h, k, &tk);
        q.push_back(e);
        if (ins == 8'hc0) exp_seek = 1'b0;
        if (ins == 8'ha2 && p2[4] && k.proactive_pending && e == 16'h9000) exp_seek = 1'b1;
    endtask

    task automatic summarize();
        $display("Mismatches %0d, comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ======================================================
    // Watcher and hang guard
    always @(posedge core_clk) begin
        #1;
        if (sw_valid === 1'b1) check(status_word, q.size() ? q.pop_front() : 16'hxxxx);
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            summarize();
        end
    end

    initial begin
        repeat (4) @(posedge core_clk);
        #2 arst_n = 1'b1;
        check(status_word, 16'h9000);
        check({14'h0, sw_valid, seek_pending}, 16'h0000);
        c = OK;
        c.class_ok = 1'b0;
        c.tech_fault = 1'b1;
        send(8'h77, 8'h00, c, 2'b11);
        c = OK;
        c.tech_fault = 1'b1;
        c.param_ok = 1'b0;
        send(8'h77, 8'h00, c, 2'b11);
        send(8'hb0, 8'h00, c, 2'b11);
        c = OK;
        c.record_out_of_range = 1'b1;
        c.param_ok = 1'b0;
        c.length_ok = 1'b0;
        send(8'hb2, 8'h00, c, 2'b11);
        send(8'h20, 8'h00, c, 2'b11);
        c = OK;
        c.length_ok = 1'b0;
        c.right_length = 8'h1a;
        c.toolkit_busy = 1'b1;
        send(8'h10, 8'h00, c, 2'b11);
        c.right_length = 8'h00;
        send(8'hb0, 8'h00, c, 2'b11);
        c = OK;
        c.toolkit_busy = 1'b1;
        c.proactive_pending = 1'b1;
        c.proactive_length = 8'h2c;
        send(8'h10, 8'h00, c, 2'b11);
        send(8'h10, 8'h00, c, 2'b10);
        send(8'hb0, 8'h00, c, 2'b01);
        send(8'ha2, 8'h00, c, 2'b11);
        send(8'ha2, 8'h10, c, 2'b11);
        hs_u.idle();
        check({15'h0, seek_pending}, {15'h0, exp_seek});
        send(8'hc0, 8'h00, c, 2'b11);
        foreach (tbl[i]) if (i == 1 || i == 11 || i == 12) send(tbl[i], 8'h00, c, 2'b11);
        hs_u.idle();
        check({15'h0, seek_pending}, {15'h0, exp_seek});
        // Random traffic, tech faults thinned so later checks get reached
        for (int i = 0; i < 80; i++) begin
            c = 37'({$random(seed), $random(seed)});
            c.tech_fault &= c.toolkit_busy;
            send(tbl[$unsigned($random(seed)) % 18], 8'h00, c, 2'($random(seed)));
        end
        hs_u.idle();
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            #2;
            fill_valid = 1'b1;
            fill_kind = sw_enc_pkg::fill_kind_t'(i % 4);
            fill_addr = `FILE_AW'(i);
            fill_data = 8'($random(seed)) | 8'h80;
            fill_last = i[2];
            fexp[i] = (i % 2 == 0) ? 8'hff : (i % 4 == 1) ? (fill_last ? 8'hfe : fill_data)
                    : (fill_data & 8'h7f);
        end
        @(posedge core_clk);
        #2 fill_valid = 1'b0;
        for (int i = 0; i < 8; i++) begin
            file_raddr = `FILE_AW'(i);
            repeat (2) @(posedge core_clk);
            #1 check({8'h00, file_rdata}, {8'h00, fexp[i]});
            #1;
        end
        repeat (3) @(posedge core_clk);
        check(16'(q.size()), 16'h0000);
        summarize();
    end
endmodule
